// ---- phy_mgmt_map.svh ----
`ifndef PHY_MGMT_MAP_SVH
`define PHY_MGMT_MAP_SVH

// management register addresses, as five-bit register numbers
`define ADDR_PLL_CONTROL        5'h10
`define ADDR_STRAP_OVERRIDE     5'h16
`define ADDR_STRAP_STATUS       5'h17
`define ADDR_EXPANDED_CONTROL   5'h18
`define ADDR_INTERRUPT_CONTROL  5'h1b

// strap override fields
`define OVR_RMII_BIT            1
`define OVR_NAND_TREE_BIT       5
`define OVR_BACK_TO_BACK_BIT    6
`define OVR_RESET               16'h0002
`define OVR_WRITE_MASK          16'hfbff

// strap status fields
`define STAT_PHYAD_MSB          15
`define STAT_PHYAD_LSB          13
`define STAT_RMII_BIT           1

// expanded control and pll control
`define ECTL_ENERGY_DETECT_POWERDOWN_DISABLE_BIT   11
`define ECTL_RESET              16'h0800
`define DCTL_PLL_OFF_BIT        4
`define DCTL_RESET              16'h0000

// interrupt control: enables in the upper byte, event flags in the lower
`define INT_EN_RESET            8'h00
`define INT_FLAG_COUNT          8

// serial management frame
`define MDIO_OP_READ            2'b10
`define MDIO_OP_WRITE           2'b01
`define MDIO_PREAMBLE_LEN       6'd32
`define MDIO_HDR_LAST           5'd11
`define MDIO_DATA_LAST          5'd15
`define MDIO_WR_LAST            5'd17

// mclk cycles after reset release before the straps are taken
`define STRAP_SETTLE            2'd3

`endif

// ---- phy_mgmt_pkg.sv ----
package phy_mgmt_pkg;

    typedef enum logic [2:0] {
        ST_PREAMBLE,
        ST_START,
        ST_HEADER,
        ST_TA_FLOAT,
        ST_TA_ZERO,
        ST_READ_DATA,
        ST_WRITE_DATA
    } mdio_state_t;

    typedef struct packed {
        mdio_state_t state;
        logic [5:0]  ones;
        logic [4:0]  cnt;
        logic [10:0] hdr;
        logic [15:0] shift;
        logic        wr_hit;
        logic [4:0]  reg_sel;
        logic        mdc_prev;
        logic        mdio_out;
        logic        mdio_oe;
        logic        rd_clear;
        logic [15:0] ovr;
        logic [15:0] ectl;
        logic [15:0] dctl;
        logic [7:0]  int_en;
        logic [1:0]  strap_cnt;
        logic        strap_done;
        logic [2:0]  phyad;
        logic        rmii_s;
        logic        b2b_s;
        logic        nand_s;
    } mgmt_state_t;

    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] q;
    } sync_state_t;

endpackage

// ---- bit_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for up to eight pin inputs
module bit_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    phy_mgmt_pkg::sync_state_t cur;
    phy_mgmt_pkg::sync_state_t next_cur;

    // meta stage feeds only the second stage
    always_comb
    begin
        next_cur      = cur;
        next_cur.meta = 8'h00;
        next_cur.meta[WIDTH-1:0] = d;
        next_cur.q    = cur.meta;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign q = cur.q[WIDTH-1:0];

endmodule // bit_sync

`default_nettype wire

// ---- sticky_flags.sv ----
`timescale 1ns/1ps
`default_nettype none

// sticky event flags, cleared as a group; a same-cycle event wins
module sticky_flags
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] set_pulse,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] cur;
    logic [WIDTH-1:0] next_cur;

    // set after clear so no event is lost on a read
    always_comb
    begin
        next_cur = (clear ? '0 : cur) | set_pulse;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign flags = cur;

endmodule // sticky_flags

`default_nettype wire

// ---- phy_strap_energy_detect_powerdown_irq_regs.sv ----
// Notes on behaviour
// - back-to-back override bit forces back-to-back mode
// - nand-tree override bit forces nand tree mode
// - rmii override bit rw, resets one, forces rmii
// - status bits 15:13 show latched phy address
// - status bit 1 shows rmii strap, rest zero
// - expanded control bit 11 disables energy-detect powerdown
// - pll-off bit acts while powerdown enabled
// - bit 15 enables jabber interrupt
// - bit 14 enables receive error interrupt
// - bit 13 enables page received interrupt
// - bit 12 enables parallel detect fault interrupt
// - bit 11 enables link partner acknowledge interrupt
// - bit 10 enables link-down interrupt
// - bit 9 enables remote fault interrupt
// - low byte flags set by events, clear-on-read
`include "phy_mgmt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module phy_strap_energy_detect_powerdown_irq_regs
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic [2:0] phy_address_strap,
    input  wire logic       rmii_strap,
    input  wire logic       back_to_back_strap,
    input  wire logic       nand_tree_strap,
    input  wire logic [7:0] irq_event,
    output logic            rmii_mode,
    output logic            back_to_back_repeater_override,
    output logic            nand_tree_mode,
    output logic            energy_detect_powerdown,
    output logic            pll_auto_off,
    output logic            interrupt_request
);

    phy_mgmt_pkg::mgmt_state_t cur;
    phy_mgmt_pkg::mgmt_state_t next_cur;

    logic       mdc_s;
    logic       mdio_s;
    logic [5:0] strap_s;
    logic [7:0] int_flags;
    logic       mdc_rise;
    logic [4:0] own_addr;
    logic [15:0] hdr_full;

    // pins come from outside mclk, so each passes two flops
    bit_sync #(.WIDTH(2)) u_mdio_sync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({mdc, mdio_in}),
        .q     ({mdc_s, mdio_s})
    );

    bit_sync #(.WIDTH(6)) u_strap_sync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({phy_address_strap, rmii_strap, back_to_back_strap, nand_tree_strap}),
        .q     (strap_s)
    );

    // event flags of the interrupt register's low byte
    sticky_flags #(.WIDTH(`INT_FLAG_COUNT)) u_flags
    (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .set_pulse (irq_event),
        .clear     (cur.rd_clear),
        .flags     (int_flags)
    );

    assign mdc_rise = mdc_s & ~cur.mdc_prev;
    assign own_addr = {2'b00, cur.phyad};
    assign hdr_full = {4'h0, cur.hdr, mdio_s};

    // read view of the register slice; unmapped addresses read zero
    function automatic logic [15:0] read_mux(input logic [4:0] addr,
                                             input phy_mgmt_pkg::mgmt_state_t s,
                                             input logic [7:0] fl);
        logic [15:0] v;
        v = 16'h0000;
        unique case (addr)
            `ADDR_PLL_CONTROL:       v = s.dctl;
            `ADDR_STRAP_OVERRIDE:    v = s.ovr;
            `ADDR_STRAP_STATUS:
            begin
                v[`STAT_PHYAD_MSB:`STAT_PHYAD_LSB] = s.phyad;
                v[`STAT_RMII_BIT] = s.rmii_s;
            end
            `ADDR_EXPANDED_CONTROL:  v = s.ectl;
            `ADDR_INTERRUPT_CONTROL: v = {s.int_en, fl};
            default:                 v = 16'h0000;
        endcase
        return v;
    endfunction

    // frame decoder, register writes and strap capture
    always_comb
    begin
        next_cur          = cur;
        next_cur.mdc_prev = mdc_s;
        next_cur.rd_clear = 1'b0;

        // straps taken once, a few cycles after reset release
        if (!cur.strap_done)
        begin
            if (cur.strap_cnt == `STRAP_SETTLE)
            begin
                next_cur.strap_done = 1'b1;
                next_cur.phyad      = strap_s[5:3];
                next_cur.rmii_s     = strap_s[2];
                next_cur.b2b_s      = strap_s[1];
                next_cur.nand_s     = strap_s[0];
            end
            else
                next_cur.strap_cnt = cur.strap_cnt + 2'd1;
        end

        if (mdc_rise)
        begin
            unique case (cur.state)
                phy_mgmt_pkg::ST_PREAMBLE:
                begin
                    // a zero after a full preamble is the first start bit
                    if (mdio_s)
                    begin
                        if (cur.ones != `MDIO_PREAMBLE_LEN)
                            next_cur.ones = cur.ones + 6'd1;
                    end
                    else if (cur.ones == `MDIO_PREAMBLE_LEN)
                        next_cur.state = phy_mgmt_pkg::ST_START;
                    else
                        next_cur.ones = 6'd0;
                end
                phy_mgmt_pkg::ST_START:
                begin
                    next_cur.ones = 6'd0;
                    next_cur.cnt  = 5'd0;
                    next_cur.state = mdio_s ? phy_mgmt_pkg::ST_HEADER : phy_mgmt_pkg::ST_PREAMBLE;
                end
                phy_mgmt_pkg::ST_HEADER:
                begin
                    next_cur.hdr = {cur.hdr[9:0], mdio_s};
                    next_cur.cnt = cur.cnt + 5'd1;
                    if (cur.cnt == `MDIO_HDR_LAST)
                    begin
                        next_cur.cnt     = 5'd0;
                        next_cur.reg_sel = hdr_full[4:0];
                        if (hdr_full[11:10] == `MDIO_OP_READ && hdr_full[9:5] == own_addr)
                        begin
                            // snapshot now; reading the flags clears them
                            // same-cycle events join the snapshot, else the clear would lose them
                            next_cur.shift = read_mux(hdr_full[4:0], cur, int_flags | irq_event);
                            next_cur.rd_clear = (hdr_full[4:0] == `ADDR_INTERRUPT_CONTROL);
                            next_cur.state = phy_mgmt_pkg::ST_TA_FLOAT;
                        end
                        else
                        begin
                            // foreign frames are walked through so we stay aligned
                            next_cur.wr_hit = (hdr_full[11:10] == `MDIO_OP_WRITE) && (hdr_full[9:5] == own_addr);
                            next_cur.state  = phy_mgmt_pkg::ST_WRITE_DATA;
                        end
                    end
                end
                phy_mgmt_pkg::ST_TA_FLOAT:
                begin
                    next_cur.mdio_oe  = 1'b1;
                    next_cur.mdio_out = 1'b0;
                    next_cur.state    = phy_mgmt_pkg::ST_TA_ZERO;
                end
                phy_mgmt_pkg::ST_TA_ZERO:
                begin
                    next_cur.mdio_out = cur.shift[15];
                    next_cur.shift    = {cur.shift[14:0], 1'b0};
                    next_cur.state    = phy_mgmt_pkg::ST_READ_DATA;
                end
                phy_mgmt_pkg::ST_READ_DATA:
                begin
                    next_cur.cnt = cur.cnt + 5'd1;
                    if (cur.cnt == `MDIO_DATA_LAST)
                    begin
                        next_cur.mdio_oe  = 1'b0;
                        next_cur.mdio_out = 1'b0;
                        next_cur.cnt      = 5'd0;
                        next_cur.state    = phy_mgmt_pkg::ST_PREAMBLE;
                    end
                    else
                    begin
                        next_cur.mdio_out = cur.shift[15];
                        next_cur.shift    = {cur.shift[14:0], 1'b0};
                    end
                end
                phy_mgmt_pkg::ST_WRITE_DATA:
                begin
                    // two turnaround bits then sixteen data bits
                    next_cur.shift = {cur.shift[14:0], mdio_s};
                    next_cur.cnt   = cur.cnt + 5'd1;
                    if (cur.cnt == `MDIO_WR_LAST)
                    begin
                        next_cur.cnt    = 5'd0;
                        next_cur.wr_hit = 1'b0;
                        next_cur.state  = phy_mgmt_pkg::ST_PREAMBLE;
                        if (cur.wr_hit)
                        begin
                            unique case (cur.reg_sel)
                                `ADDR_PLL_CONTROL:
                                    next_cur.dctl = {cur.shift[14:0], mdio_s};
                                `ADDR_STRAP_OVERRIDE:
                                    // bit 10 stays zero; all others store
                                    next_cur.ovr = {cur.shift[14:0], mdio_s} & `OVR_WRITE_MASK;
                                `ADDR_EXPANDED_CONTROL:
                                    next_cur.ectl = {cur.shift[14:0], mdio_s};
                                `ADDR_INTERRUPT_CONTROL:
                                    // only the enables are writable, flags ignore writes
                                    next_cur.int_en = cur.shift[14:7];
                                default:
                                    next_cur.wr_hit = 1'b0;
                            endcase
                        end
                    end
                end
                default:
                    next_cur.state = phy_mgmt_pkg::ST_PREAMBLE;
            endcase
        end
    end

    // register bank resets to documented defaults
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur        <= '0;
            cur.state  <= phy_mgmt_pkg::ST_PREAMBLE;
            cur.ovr    <= `OVR_RESET;
            cur.ectl   <= `ECTL_RESET;
            cur.dctl   <= `DCTL_RESET;
            cur.int_en <= `INT_EN_RESET;
        end
        else
            cur <= next_cur;
    end

    assign mdio_out = cur.mdio_out;
    assign mdio_oe  = cur.mdio_oe;

    // mode outputs follow the override bits the cycle after the write
    assign rmii_mode = cur.ovr[`OVR_RMII_BIT] | cur.rmii_s;
    // software is expected to set rmii override alongside this one
    assign back_to_back_repeater_override = cur.ovr[`OVR_BACK_TO_BACK_BIT] | cur.b2b_s;
    assign nand_tree_mode = cur.ovr[`OVR_NAND_TREE_BIT] | cur.nand_s;

    // powerdown enabled while the disable bit is clear
    assign energy_detect_powerdown = ~cur.ectl[`ECTL_ENERGY_DETECT_POWERDOWN_DISABLE_BIT];
    assign pll_auto_off = energy_detect_powerdown & cur.dctl[`DCTL_PLL_OFF_BIT];

    // enable bit n+8 gates flag n; bit 8 pairs with link-up
    assign interrupt_request = |(int_flags & cur.int_en);

endmodule // phy_strap_energy_detect_powerdown_irq_regs

`default_nettype wire

// ---- phy_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module phy_regs_monitor
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       mdc,
    input wire logic       mdio_in,
    input wire logic       mdio_out,
    input wire logic       mdio_oe,
    input wire logic [2:0] phy_address_strap,
    input wire logic       rmii_strap,
    input wire logic       back_to_back_strap,
    input wire logic       nand_tree_strap,
    input wire logic [7:0] irq_event,
    input wire logic       rmii_mode,
    input wire logic       back_to_back_repeater_override,
    input wire logic       nand_tree_mode,
    input wire logic       energy_detect_powerdown,
    input wire logic       pll_auto_off,
    input wire logic       interrupt_request
);
    logic       mdc_d;
    logic       seen_event;
    logic [4:0] oe_rises;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // mdc rises seen while the device holds the line; no irq is legal before any event
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdc_d      <= 1'b0;
            seen_event <= 1'b0;
            oe_rises   <= 5'h00;
        end
        else
        begin
            mdc_d      <= mdc;
            seen_event <= seen_event | (|irq_event);
            oe_rises   <= mdio_oe ? oe_rises + 5'(mdc & ~mdc_d) : 5'h00;
        end
    end

    a_modes_reset: assert property (
        $rose(rst_n) |-> rmii_mode && !energy_detect_powerdown && !pll_auto_off)
        else $error("mode outputs wrong after reset");
    a_force_reset: assert property (
        $rose(rst_n) |-> !back_to_back_repeater_override && !nand_tree_mode)
        else $error("forced modes set after reset");
    a_pll_needs_pwrdn: assert property (
        pll_auto_off |-> energy_detect_powerdown)
        else $error("pll off without powerdown");
    a_irq_needs_event: assert property (
        !seen_event |-> !interrupt_request)
        else $error("interrupt with no event");
    a_irq_drop_read: assert property (
        $fell(interrupt_request) |-> mdc)
        else $error("interrupt dropped outside a frame");
    a_pwrdn_on_write: assert property (
        $changed(energy_detect_powerdown) || $changed(pll_auto_off) |-> mdc)
        else $error("powerdown changed outside a write");
    a_out_on_rise: assert property (
        mdio_oe && $changed(mdio_out) |-> mdc)
        else $error("read data moved while mdc low");
    a_turn_zero: assert property (
        $rose(mdio_oe) |-> mdc && !mdio_out ##1 mdio_oe [*8])
        else $error("turnaround not driven low");
    a_drive_bounded: assert property (
        oe_rises <= 5'd17)
        else $error("device drove beyond data word");
endmodule // phy_regs_monitor

bind phy_strap_energy_detect_powerdown_irq_regs phy_regs_monitor mon
(
    .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .phy_address_strap(phy_address_strap), .rmii_strap(rmii_strap),
    .back_to_back_strap(back_to_back_strap), .nand_tree_strap(nand_tree_strap), .irq_event(irq_event),
    .rmii_mode(rmii_mode), .back_to_back_repeater_override(back_to_back_repeater_override),
    .nand_tree_mode(nand_tree_mode), .energy_detect_powerdown(energy_detect_powerdown),
    .pll_auto_off(pll_auto_off), .interrupt_request(interrupt_request)
);

`default_nettype wire

// ---- mdio_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module mdio_host
(
    input  wire logic mclk,
    input  wire logic mdio_oe,
    input  wire logic mdio_out,
    output logic      mdc,
    output logic      mdio_in
);
    localparam int HALF = 20; // 2.5 mhz mdc, slow enough for the synchroniser
    logic drive;
    logic bit_out;

    // released line floats to the pull-up level
    assign mdio_in = mdio_oe ? mdio_out : (drive ? bit_out : 1'b1);

    // mdc stands low between frames
    initial
    begin
        mdc = 1'b0;
        drive = 1'b0;
        bit_out = 1'b1;
    end

    // one mdc period: data set while low, line sampled at the rise
    task automatic tick(input logic b, output logic s);
        @(negedge mclk);
        bit_out = b;
        repeat (HALF) @(negedge mclk);
        mdc = 1'b1;
        s = mdio_in;
        repeat (HALF) @(negedge mclk);
        mdc = 1'b0;
    endtask

    // full frame with fresh preamble; a read releases the line for turnaround
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        logic        s;
        f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        drive = 1'b1;
        for (int i = 63; i >= 0; i--)
        begin
            if (i == 17 && op == 2'b10)
                drive = 1'b0;
            tick(f[i], s);
            rd[i % 16] = s;
        end
        drive = 1'b0;
    endtask
endmodule // mdio_host

`default_nettype wire

// ---- phy_strap_energy_detect_powerdown_irq_regs_bench.sv ----
`include "phy_mgmt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module phy_strap_energy_detect_powerdown_irq_regs_bench;
    logic       mclk;
    logic       rst_n;
    logic [7:0] irq_event;
    logic       mdc, mdio_in, mdio_out, mdio_oe;
    logic       rmii_mode, btb_mode, nand_mode, pwrdn, pll_off, irq;
    wire  [5:0] modes;
    int         errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    // straps tied: address 3, no mode straps, so overrides alone drive the modes
    phy_strap_energy_detect_powerdown_irq_regs dut
    (
        .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .phy_address_strap(3'h3), .rmii_strap(1'b0), .back_to_back_strap(1'b0), .nand_tree_strap(1'b0),
        .irq_event(irq_event), .rmii_mode(rmii_mode), .back_to_back_repeater_override(btb_mode),
        .nand_tree_mode(nand_mode), .energy_detect_powerdown(pwrdn), .pll_auto_off(pll_off),
        .interrupt_request(irq)
    );
    mdio_host host
    (
        .mclk(mclk), .mdio_oe(mdio_oe), .mdio_out(mdio_out), .mdc(mdc), .mdio_in(mdio_in)
    );

    assign modes = {rmii_mode, btb_mode, nand_mode, pwrdn, pll_off, irq};

    initial
    begin
        mclk = 1'b0;
    end
    always #5 mclk = ~mclk;

    task automatic conclude;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
            errors++;
        if (seen !== exp)
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] r;
        host.frame(2'b01, 5'h03, ra, d, r);
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] r;
        host.frame(2'b10, 5'h03, ra, 16'h0000, r);
        check(r, exp);
    endtask

    task automatic pulse(input logic [7:0] ev);
        @(negedge mclk);
        irq_event = ev;
        @(negedge mclk);
        irq_event = 8'h00;
        repeat (3) @(negedge mclk);
    endtask

    task automatic t_reset;
        check(16'(modes), 16'h0020);
        rd(`ADDR_STRAP_OVERRIDE, 16'h0002);
        rd(`ADDR_STRAP_STATUS, 16'h6000);
        rd(`ADDR_EXPANDED_CONTROL, 16'h0800);
        rd(`ADDR_PLL_CONTROL, 16'h0000);
        rd(`ADDR_INTERRUPT_CONTROL, 16'h0000);
    endtask

    // rmii set alongside back-to-back, as software must
    task automatic t_override;
        wr(`ADDR_STRAP_OVERRIDE, 16'h0042);
        check(16'(modes), 16'h0030);
        wr(`ADDR_STRAP_OVERRIDE, 16'h0020);
        check(16'(modes), 16'h0008);
        wr(`ADDR_STRAP_OVERRIDE, 16'hffff);
        rd(`ADDR_STRAP_OVERRIDE, 16'hfbff);
        wr(`ADDR_STRAP_OVERRIDE, 16'h0002);
    endtask

    // status is read-only; a frame to another address is ignored
    task automatic t_status;
        logic [15:0] r;
        wr(`ADDR_STRAP_STATUS, 16'hffff);
        rd(`ADDR_STRAP_STATUS, 16'h6000);
        host.frame(2'b01, 5'h00, `ADDR_EXPANDED_CONTROL, 16'h0000, r);
        check(16'(modes), 16'h0020);
    endtask

    task automatic t_pwrdn;
        wr(`ADDR_EXPANDED_CONTROL, 16'h0000);
        check(16'(modes), 16'h0024);
        wr(`ADDR_PLL_CONTROL, 16'h0010);
        check(16'(modes), 16'h0026);
        wr(`ADDR_EXPANDED_CONTROL, 16'hf7ff);
        rd(`ADDR_EXPANDED_CONTROL, 16'hf7ff);
        wr(`ADDR_EXPANDED_CONTROL, 16'h0800);
        check(16'(modes), 16'h0020);
    endtask

    // each enable from bit 9 to bit 15 alone; its lower neighbour event must not raise the request
    task automatic t_irq;
        logic [15:0] en;
        for (int n = 1; n < 8; n++)
        begin
            en = 16'h0100 << n;
            wr(`ADDR_INTERRUPT_CONTROL, en | 16'h00ff);
            pulse(8'h01 << (n - 1));
            check(16'(irq), 16'h0000);
            pulse(8'h01 << n);
            check(16'(irq), 16'h0001);
            rd(`ADDR_INTERRUPT_CONTROL, en | (16'h0003 << (n - 1)));
            check(16'(irq), 16'h0000);
        end
    endtask

    initial
    begin
        rst_n = 1'b0;
        irq_event = 8'h00;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (10) @(negedge mclk);
        t_reset;
        t_override;
        t_status;
        t_pwrdn;
        t_irq;
        conclude;
    end

    // about 32 frames of 2600 cycles each
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 95000)
            errors++;
        if (cycles == 95000)
            conclude;
    end
endmodule // phy_strap_energy_detect_powerdown_irq_regs_bench

`default_nettype wire
